// ---- logic/pmx_pkg.sv ----
// Notes on behaviour
// - Eight-pin: shared debug pin starts as input.
// - Low run during reset sequence unlocks debug.
// - No unlock seen: debug stays locked until reset.
// - Crystal enabled: bits zero and one disabled.
// - Eight-pin: external clock comes from bit one.
// - Wider parts: enable connects the single function.
// - Wider parts: fixed timer, serial, timer mapping.
// - Timer configuration picks input or inverted output.
// - Ports B, C: enable plus low select only.
// - Port D bit zero: enable selects function.
// - Bit zero: 00 timer input, 11 inverted out.
// - Bit two: driver enable, reset, timer1 out.
// - Bit three: CTS, comparator, timer1 in, analog.
// - Bits four, five: serial, analog; bit five also inverted timer1.
package pmx_pkg;
  localparam logic [7:0] OFF_PA_AF = 8'h00;
  localparam logic [7:0] OFF_PA_FSL = 8'h04;
  localparam logic [7:0] OFF_PA_FSH = 8'h08;
  localparam logic [7:0] OFF_PA_OUT = 8'h0C;
  localparam logic [7:0] OFF_PA_DIR = 8'h10;
  localparam logic [7:0] OFF_PA_IN = 8'h14;
  localparam logic [7:0] OFF_OSC = 8'h18;
  localparam logic [7:0] OFF_PB_AF = 8'h1C;
  localparam logic [7:0] OFF_PB_FSL = 8'h20;
  localparam logic [7:0] OFF_PC_AF = 8'h24;
  localparam logic [7:0] OFF_PC_FSL = 8'h28;
  localparam logic [7:0] OFF_PD_AF = 8'h2C;
  localparam logic [7:0] OFF_STATUS = 8'h30;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_OSC = 2'h0;
  localparam int OSC_XTAL_BIT = 0;
  localparam int OSC_EXT_BIT = 1;
  localparam int STAT_UNLOCK_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_XTAL_BIT = 2;
  localparam int PB_EXTERNAL_CLOCK_INPUT_BIT = 3;
  localparam int PD_FN_BIT = 0;
  localparam int unsigned UNLOCK_LOW_CYCLES = 16;

  typedef enum logic [4:0] {
    FN_GPIO, FN_OFF, FN_DEBUG, FN_T0_IN, FN_T0_OUT, FN_T0_OUT_N, FN_T1_IN, FN_T1_OUT, FN_T1_OUT_N,
    FN_DRV_EN, FN_EXT_RST, FN_EXT_CLK, FN_CTS, FN_RX, FN_TX, FN_COMP, FN_ANALOG
  } pmx_fn_t;

  typedef struct packed {
    logic timer0_output;
    logic timer1_output;
    logic timer0_pin_is_input;
    logic timer1_pin_is_input;
    logic serial_driver_enable;
    logic serial_transmit;
    logic comparator_output;
    logic debug_out;
    logic debug_oe;
  } pmx_from_periph_t;

  typedef struct packed {
    logic timer0_input;
    logic timer1_input;
    logic serial_clear_to_send;
    logic serial_receive;
    logic external_clock_input;
    logic external_reset_request;
    logic debug_in;
  } pmx_to_periph_t;
endpackage

// ---- logic/pmx_debug_unlock.sv ----
`timescale 1ns/10ps
module pmx_debug_unlock #(
  parameter int unsigned LOW_CYCLES = pmx_pkg::UNLOCK_LOW_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic reset_sequence,
  input wire logic pin_level,
  output logic unlocked,
  output logic decided
);
  localparam int unsigned CW = $clog2(LOW_CYCLES + 1);

  logic [CW-1:0] run_reg;
  logic seen_reg;
  logic run_done;

  assign run_done = (run_reg == CW'(LOW_CYCLES - 1));

  // The unlock pattern is a run of low samples inside the reset sequence window.
  always_ff @(posedge clock) begin
    if (rst) begin
      run_reg <= '0;
    end else if (!reset_sequence || pin_level || decided) begin
      run_reg <= '0;
    end else if (!run_done) begin
      run_reg <= run_reg + CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      unlocked <= 1'b0;
    end else if (!decided && reset_sequence && !pin_level && run_done) begin
      unlocked <= 1'b1;
    end
  end

  // Once the window has closed the outcome is frozen; only rst reopens it.
  always_ff @(posedge clock) begin
    if (rst) begin
      seen_reg <= 1'b0;
      decided <= 1'b0;
    end else begin
      if (reset_sequence) begin
        seen_reg <= 1'b1;
      end
      if (seen_reg && !reset_sequence) begin
        decided <= 1'b1;
      end
    end
  end

  sequence s_low_run;
    !decided && reset_sequence && !pin_level && run_done;
  endsequence

  a_unlock_on_run: assert property (@(posedge clock) disable iff (rst) s_low_run |=> unlocked)
    else $error("debug not unlocked after low run");
  a_lock_held: assert property (@(posedge clock) disable iff (rst) decided && !unlocked |=> !unlocked)
    else $error("debug unlocked after window closed");
  a_unlock_cause: assert property (@(posedge clock) disable iff (rst)
    $rose(unlocked) |-> $past(reset_sequence) && !$past(pin_level))
    else $error("debug unlocked without low pin in window");
endmodule

// ---- logic/pmx_port_a_mux.sv ----
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module pmx_port_a_mux #(
  parameter bit EIGHT_PIN = 1'b1,
  parameter int unsigned UNLOCK_LOW_CYCLES = pmx_pkg::UNLOCK_LOW_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reset_sequence,
  input wire logic [7:0] pa_pin_in,
  output logic [7:0] pa_pin_out,
  output logic [7:0] pa_pin_oe,
  output logic [7:0] analog_connect,
  input wire logic port_b_bit_three,
  input wire pmx_pkg::pmx_from_periph_t periph_i,
  output pmx_pkg::pmx_to_periph_t periph_o,
  output logic external_clock_select,
  output logic [7:0] pb_func_first,
  output logic [7:0] pb_func_second,
  output logic [7:0] pc_func_first,
  output logic [7:0] pc_func_second,
  output logic pd_func_en
);
  logic [7:0] pa_af_reg;
  logic [7:0] pa_fsl_reg;
  logic [7:0] pa_fsh_reg;
  logic [7:0] pa_out_reg;
  logic [7:0] pa_dir_reg;
  logic [1:0] osc_reg;
  logic [7:0] pb_af_reg;
  logic [7:0] pb_fsl_reg;
  logic [7:0] pc_af_reg;
  logic [7:0] pc_fsl_reg;
  logic pd_af_reg;
  logic [7:0] pa_meta_reg;
  logic [7:0] pa_sync_reg;
  logic pb3_meta_reg;
  logic pb3_sync_reg;
  logic wb_req;
  logic [31:0] rd_word;
  logic dbg_unlocked;
  logic dbg_decided;
  logic xtal_on;
  pmx_pkg::pmx_fn_t fn [8];
  logic [7:0] out_next;
  logic [7:0] oe_next;
  logic [7:0] ana_next;
  pmx_pkg::pmx_to_periph_t to_next;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign xtal_on = osc_reg[pmx_pkg::OSC_XTAL_BIT];

  // Pads are asynchronous to the system clock.
  always_ff @(posedge clock) begin
    if (rst) begin
      pa_meta_reg <= pmx_pkg::RST_BYTE;
      pa_sync_reg <= pmx_pkg::RST_BYTE;
      pb3_meta_reg <= 1'b0;
      pb3_sync_reg <= 1'b0;
    end else begin
      pa_meta_reg <= pa_pin_in;
      pa_sync_reg <= pa_meta_reg;
      pb3_meta_reg <= port_b_bit_three;
      pb3_sync_reg <= pb3_meta_reg;
    end
  end

  // Registers hold at most one byte (OSC two bits, PD one bit) in lane 0; other lanes are ignored.
  always_ff @(posedge clock) begin
    if (rst) begin
      pa_af_reg <= pmx_pkg::RST_BYTE;
      pa_fsl_reg <= pmx_pkg::RST_BYTE;
      pa_fsh_reg <= pmx_pkg::RST_BYTE;
      pa_out_reg <= pmx_pkg::RST_BYTE;
      pa_dir_reg <= pmx_pkg::RST_BYTE;
      osc_reg <= pmx_pkg::RST_OSC;
      pb_af_reg <= pmx_pkg::RST_BYTE;
      pb_fsl_reg <= pmx_pkg::RST_BYTE;
      pc_af_reg <= pmx_pkg::RST_BYTE;
      pc_fsl_reg <= pmx_pkg::RST_BYTE;
      pd_af_reg <= 1'b0;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        pmx_pkg::OFF_PA_AF: pa_af_reg <= wb_dat_i[7:0];
        pmx_pkg::OFF_PA_FSL: pa_fsl_reg <= wb_dat_i[7:0];
        pmx_pkg::OFF_PA_FSH: pa_fsh_reg <= wb_dat_i[7:0];
        pmx_pkg::OFF_PA_OUT: pa_out_reg <= wb_dat_i[7:0];
        pmx_pkg::OFF_PA_DIR: pa_dir_reg <= wb_dat_i[7:0];
        pmx_pkg::OFF_OSC: osc_reg <= wb_dat_i[1:0];
        pmx_pkg::OFF_PB_AF: pb_af_reg <= wb_dat_i[7:0];
        pmx_pkg::OFF_PB_FSL: pb_fsl_reg <= wb_dat_i[7:0];
        pmx_pkg::OFF_PC_AF: pc_af_reg <= wb_dat_i[7:0];
        pmx_pkg::OFF_PC_FSL: pc_fsl_reg <= wb_dat_i[7:0];
        pmx_pkg::OFF_PD_AF: pd_af_reg <= wb_dat_i[pmx_pkg::PD_FN_BIT];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_word = '0;
    case (wb_adr_i)
      pmx_pkg::OFF_PA_AF: rd_word[7:0] = pa_af_reg;
      pmx_pkg::OFF_PA_FSL: rd_word[7:0] = pa_fsl_reg;
      pmx_pkg::OFF_PA_FSH: rd_word[7:0] = pa_fsh_reg;
      pmx_pkg::OFF_PA_OUT: rd_word[7:0] = pa_out_reg;
      pmx_pkg::OFF_PA_DIR: rd_word[7:0] = pa_dir_reg;
      pmx_pkg::OFF_PA_IN: rd_word[7:0] = pa_sync_reg;
      pmx_pkg::OFF_OSC: rd_word[1:0] = osc_reg;
      pmx_pkg::OFF_PB_AF: rd_word[7:0] = pb_af_reg;
      pmx_pkg::OFF_PB_FSL: rd_word[7:0] = pb_fsl_reg;
      pmx_pkg::OFF_PC_AF: rd_word[7:0] = pc_af_reg;
      pmx_pkg::OFF_PC_FSL: rd_word[7:0] = pc_fsl_reg;
      pmx_pkg::OFF_PD_AF: rd_word[pmx_pkg::PD_FN_BIT] = pd_af_reg;
      pmx_pkg::OFF_STATUS: begin
        rd_word[pmx_pkg::STAT_UNLOCK_BIT] = dbg_unlocked;
        rd_word[pmx_pkg::STAT_DONE_BIT] = dbg_decided;
        rd_word[pmx_pkg::STAT_XTAL_BIT] = xtal_on;
      end
      default: ;
    endcase
  end

  // Every cycle of a request answers in exactly one wait state, mapped or not.
  always_ff @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_word : '0;
    end
  end

  pmx_debug_unlock #(
    .LOW_CYCLES(UNLOCK_LOW_CYCLES)
  ) u_debug_unlock (
    .clock(clock),
    .rst(rst),
    .reset_sequence(reset_sequence),
    .pin_level(pa_sync_reg[0]),
    .unlocked(dbg_unlocked),
    .decided(dbg_decided)
  );

  // Reserved codes and disabled pins decode to FN_GPIO.
  function automatic pmx_pkg::pmx_fn_t pa_decode(input int pin, input logic en, input logic [1:0] code,
                                                 input logic t0_in, input logic t1_in);
    pmx_pkg::pmx_fn_t f;
    f = pmx_pkg::FN_GPIO;
    if (en && EIGHT_PIN) begin
      case (pin)
        0: f = (code == 2'b00) ? pmx_pkg::FN_T0_IN : (code == 2'b11) ? pmx_pkg::FN_T0_OUT_N : pmx_pkg::FN_GPIO;
        1: f = (code == 2'b00) ? pmx_pkg::FN_T0_OUT : (code == 2'b10) ? pmx_pkg::FN_EXT_CLK :
               (code == 2'b11) ? pmx_pkg::FN_ANALOG : pmx_pkg::FN_GPIO;
        2: f = (code == 2'b00) ? pmx_pkg::FN_DRV_EN : (code == 2'b01) ? pmx_pkg::FN_EXT_RST :
               (code == 2'b10) ? pmx_pkg::FN_T1_OUT : pmx_pkg::FN_GPIO;
        3: f = (code == 2'b00) ? pmx_pkg::FN_CTS : (code == 2'b01) ? pmx_pkg::FN_COMP :
               (code == 2'b10) ? pmx_pkg::FN_T1_IN : pmx_pkg::FN_ANALOG;
        4: f = (code == 2'b00) ? pmx_pkg::FN_RX : (code == 2'b11) ? pmx_pkg::FN_ANALOG : pmx_pkg::FN_GPIO;
        5: f = (code == 2'b00) ? pmx_pkg::FN_TX : (code == 2'b01) ? pmx_pkg::FN_T1_OUT_N :
               (code == 2'b11) ? pmx_pkg::FN_ANALOG : pmx_pkg::FN_GPIO;
        default: f = pmx_pkg::FN_GPIO;
      endcase
    end else if (en) begin
      case (pin)
        0: f = t0_in ? pmx_pkg::FN_T0_IN : pmx_pkg::FN_T0_OUT_N;
        1: f = pmx_pkg::FN_T0_OUT;
        2: f = pmx_pkg::FN_DRV_EN;
        3: f = pmx_pkg::FN_CTS;
        4: f = pmx_pkg::FN_RX;
        5: f = pmx_pkg::FN_TX;
        6: f = t1_in ? pmx_pkg::FN_T1_IN : pmx_pkg::FN_T1_OUT_N;
        default: f = pmx_pkg::FN_T1_OUT;
      endcase
    end
    return f;
  endfunction

  // Crystal override beats the debug pin, which beats the select registers.
  for (genvar i = 0; i < 8; i++) begin : g_pin
    assign fn[i] = (xtal_on && i < 2) ? pmx_pkg::FN_OFF :
                   (EIGHT_PIN && i == 0 && dbg_unlocked) ? pmx_pkg::FN_DEBUG :
                   pa_decode(i, pa_af_reg[i], {pa_fsl_reg[i], pa_fsh_reg[i]},
                             periph_i.timer0_pin_is_input, periph_i.timer1_pin_is_input);
  end

  always_comb begin
    out_next = '0;
    oe_next = '0;
    ana_next = '0;
    to_next = '0;
    to_next.serial_receive = 1'b1;
    for (int k = 0; k < 8; k++) begin
      case (fn[k])
        pmx_pkg::FN_GPIO: begin
          out_next[k] = pa_out_reg[k];
          oe_next[k] = pa_dir_reg[k];
        end
        pmx_pkg::FN_DEBUG: begin
          out_next[k] = periph_i.debug_out;
          oe_next[k] = periph_i.debug_oe;
          to_next.debug_in = pa_sync_reg[k];
        end
        pmx_pkg::FN_T0_IN: to_next.timer0_input = pa_sync_reg[k];
        pmx_pkg::FN_T1_IN: to_next.timer1_input = pa_sync_reg[k];
        pmx_pkg::FN_CTS: to_next.serial_clear_to_send = pa_sync_reg[k];
        pmx_pkg::FN_RX: to_next.serial_receive = pa_sync_reg[k];
        pmx_pkg::FN_EXT_CLK: to_next.external_clock_input = pa_sync_reg[k];
        pmx_pkg::FN_EXT_RST: to_next.external_reset_request = !pa_sync_reg[k];
        pmx_pkg::FN_ANALOG: ana_next[k] = 1'b1;
        pmx_pkg::FN_T0_OUT: begin
          out_next[k] = periph_i.timer0_output;
          oe_next[k] = 1'b1;
        end
        pmx_pkg::FN_T0_OUT_N: begin
          out_next[k] = !periph_i.timer0_output;
          oe_next[k] = 1'b1;
        end
        pmx_pkg::FN_T1_OUT: begin
          out_next[k] = periph_i.timer1_output;
          oe_next[k] = 1'b1;
        end
        pmx_pkg::FN_T1_OUT_N: begin
          out_next[k] = !periph_i.timer1_output;
          oe_next[k] = 1'b1;
        end
        pmx_pkg::FN_DRV_EN: begin
          out_next[k] = periph_i.serial_driver_enable;
          oe_next[k] = 1'b1;
        end
        pmx_pkg::FN_TX: begin
          out_next[k] = periph_i.serial_transmit;
          oe_next[k] = 1'b1;
        end
        pmx_pkg::FN_COMP: begin
          out_next[k] = periph_i.comparator_output;
          oe_next[k] = 1'b1;
        end
        default: ;
      endcase
    end
    if (!EIGHT_PIN) begin
      to_next.external_clock_input = pb3_sync_reg && pb_af_reg[pmx_pkg::PB_EXTERNAL_CLOCK_INPUT_BIT];
    end
  end

  // All pin and peripheral outputs are registered to keep the pads glitch free.
  always_ff @(posedge clock) begin
    if (rst) begin
      pa_pin_out <= pmx_pkg::RST_BYTE;
      pa_pin_oe <= pmx_pkg::RST_BYTE;
      analog_connect <= pmx_pkg::RST_BYTE;
      periph_o <= '0;
      external_clock_select <= 1'b0;
      pb_func_first <= pmx_pkg::RST_BYTE;
      pb_func_second <= pmx_pkg::RST_BYTE;
      pc_func_first <= pmx_pkg::RST_BYTE;
      pc_func_second <= pmx_pkg::RST_BYTE;
      pd_func_en <= 1'b0;
    end else begin
      pa_pin_out <= out_next;
      pa_pin_oe <= oe_next;
      analog_connect <= ana_next;
      periph_o <= to_next;
      external_clock_select <= osc_reg[pmx_pkg::OSC_EXT_BIT];
      pb_func_first <= pb_af_reg & ~pb_fsl_reg;
      pb_func_second <= pb_af_reg & pb_fsl_reg;
      pc_func_first <= pc_af_reg & ~pc_fsl_reg;
      pc_func_second <= pc_af_reg & pc_fsl_reg;
      pd_func_en <= pd_af_reg;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_plain_pin3;
    EIGHT_PIN && pa_af_reg[3] && !dbg_unlocked;
  endsequence

  a_wb_ack_pulse: assert property (s_wb_req |=> s_ack_pulse)
    else $error("bus ack not a single pulse one cycle after request");
  a_powerup_input: assert property ($fell(rst) |-> pa_pin_oe == 8'h00)
    else $error("port A drives a pin straight after reset");
  a_xtal_override: assert property (xtal_on |=> pa_pin_oe[1:0] == 2'b00 && analog_connect[1:0] == 2'b00)
    else $error("crystal pins not released");
  a_pa0_t0_comp: assert property (EIGHT_PIN && pa_af_reg[0] && pa_fsl_reg[0] && pa_fsh_reg[0] && !xtal_on
    && !dbg_unlocked |=> pa_pin_oe[0] && pa_pin_out[0] == !$past(periph_i.timer0_output))
    else $error("bit zero not inverted timer0 output");
  a_pa1_ext_clock: assert property (EIGHT_PIN && pa_af_reg[1] && pa_fsl_reg[1] && !pa_fsh_reg[1] && !xtal_on
    |=> !pa_pin_oe[1] && periph_o.external_clock_input == $past(pa_sync_reg[1]))
    else $error("bit one not routed to clock input");
  a_pa2_reset_in: assert property (EIGHT_PIN && pa_af_reg[2] && !pa_fsl_reg[2] && pa_fsh_reg[2]
    |=> !pa_pin_oe[2] && periph_o.external_reset_request == !$past(pa_sync_reg[2]))
    else $error("bit two not routed to reset input");
  a_pa3_comp_out: assert property (s_plain_pin3 ##0 (!pa_fsl_reg[3] && pa_fsh_reg[3])
    |=> pa_pin_oe[3] && pa_pin_out[3] == $past(periph_i.comparator_output))
    else $error("bit three not comparator output");
  a_pa5_t1_comp: assert property (EIGHT_PIN && pa_af_reg[5] && !pa_fsl_reg[5] && pa_fsh_reg[5]
    |=> pa_pin_oe[5] && pa_pin_out[5] == !$past(periph_i.timer1_output))
    else $error("bit five not inverted timer1 output");
  a_reserved_gpio: assert property (EIGHT_PIN && pa_af_reg[4] && (pa_fsl_reg[4] ^ pa_fsh_reg[4])
    |=> pa_pin_oe[4] == $past(pa_dir_reg[4]) && pa_pin_out[4] == $past(pa_out_reg[4]))
    else $error("reserved code did not fall back to GPIO");
  a_wide_map: assert property (!EIGHT_PIN && pa_af_reg[7] |=> pa_pin_oe[7] && pa_pin_out[7] == $past(periph_i.timer1_output))
    else $error("bit seven not timer1 output");
  a_timer_pick: assert property (!EIGHT_PIN && pa_af_reg[0] && !xtal_on && periph_i.timer0_pin_is_input
    |=> !pa_pin_oe[0] && periph_o.timer0_input == $past(pa_sync_reg[0]))
    else $error("timer0 input not taken from bit zero");
endmodule

// ---- verif/pmx_pad_model.sv ----
`timescale 1ns/10ps
module pmx_pad_model (
  input wire logic [7:0] pa_pin_out,
  input wire logic [7:0] pa_pin_oe,
  input wire logic [7:0] ext_level,
  output logic [7:0] pa_pin_in
);
  // A pad the block releases falls back to the board level, never to the last driven value.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pa_pin_in[i] = pa_pin_oe[i] ? pa_pin_out[i] : ext_level[i];
    end
  end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, s) begin check_count++; if ((e) !== (s)) begin n_fail++; $display("ERROR %s expected %h seen %h", nm, e, s); end end
module testbench;
  typedef struct {int kind; logic [31:0] exp;} pmx_note_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cyc, stb, we, reset_sequence, pb3, probe;
  logic [7:0] adr, ext_level, pa_pin_in, pa_pin_out, pa_pin_oe, analog_connect, po, eoe, eout, ean;
  logic [7:0] pa_pin_in_w, pa_pin_out_w, pa_pin_oe_w;
  logic [7:0] pb_func_first, pb_func_second, pc_func_first, pc_func_second;
  logic [3:0] sel;
  logic [31:0] dat, wb_dat_o;
  logic wb_ack_o, external_clock_select, pd_func_en;
  logic [1:0] cls;
  pmx_pkg::pmx_from_periph_t periph_i;
  pmx_pkg::pmx_to_periph_t periph_o;
  pmx_pkg::pmx_to_periph_t periph_o_w;
  pmx_note_t notes[$];
  pmx_note_t nt;
  int n_fail = 0;
  int check_count = 0;
  int seed = 32'h7706_49ab;
  string names[10] = '{"read_data", "pin_oe", "pin_out", "analog", "to_periph", "ext_clock_sel", "bc_func", "d_func",
                       "wide_pins", "wide_to_periph"};
  // Pin class per select code, two bits a pin, pin five first: 0 gpio, 1 output, 2 input, 3 analog.
  logic [11:0] cls_tab [4] = '{12'h696, 12'h460, 12'h098, 12'hfcd};
  // Peripheral inputs expected per select code while the board holds the pads at 8'hfb.
  logic [6:0] to_tab [4] = '{7'h58, 7'h0a, 7'h2c, 7'h08};

  always #10 clock = ~clock;

  pmx_port_a_mux #(.EIGHT_PIN(1'b1), .UNLOCK_LOW_CYCLES(4)) u_dut (
    .clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .reset_sequence(reset_sequence), .pa_pin_in(pa_pin_in), .pa_pin_out(pa_pin_out),
    .pa_pin_oe(pa_pin_oe), .analog_connect(analog_connect), .port_b_bit_three(pb3),
    .periph_i(periph_i), .periph_o(periph_o), .external_clock_select(external_clock_select),
    .pb_func_first(pb_func_first), .pb_func_second(pb_func_second), .pc_func_first(pc_func_first),
    .pc_func_second(pc_func_second), .pd_func_en(pd_func_en)
  );

  pmx_pad_model u_pad (.pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe), .ext_level(ext_level), .pa_pin_in(pa_pin_in));

  // The wider part shares the bus with the eight-pin one, so both hold the same register values.
  pmx_port_a_mux #(.EIGHT_PIN(1'b0), .UNLOCK_LOW_CYCLES(4)) u_dut_wide (
    .clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(), .wb_ack_o(),
    .reset_sequence(reset_sequence), .pa_pin_in(pa_pin_in_w), .pa_pin_out(pa_pin_out_w),
    .pa_pin_oe(pa_pin_oe_w), .analog_connect(), .port_b_bit_three(pb3),
    .periph_i(periph_i), .periph_o(periph_o_w), .external_clock_select(),
    .pb_func_first(), .pb_func_second(), .pc_func_first(), .pc_func_second(), .pd_func_en()
  );

  pmx_pad_model u_pad_wide (.pa_pin_out(pa_pin_out_w), .pa_pin_oe(pa_pin_oe_w), .ext_level(ext_level),
                            .pa_pin_in(pa_pin_in_w));

  function automatic logic [31:0] observe(input int kind);
    case (kind)
      0: observe = wb_dat_o;
      1: observe = {24'h0, pa_pin_oe};
      2: observe = {24'h0, pa_pin_out & pa_pin_oe};
      3: observe = {24'h0, analog_connect};
      4: observe = {25'h0, periph_o};
      5: observe = {31'h0, external_clock_select};
      6: observe = {pc_func_second, pc_func_first, pb_func_second, pb_func_first};
      7: observe = {31'h0, pd_func_en};
      8: observe = {16'h0, pa_pin_oe_w, pa_pin_out_w & pa_pin_oe_w};
      default: observe = {25'h0, periph_o_w};
    endcase
  endfunction

  always @(posedge clock) begin
    if ((wb_ack_o === 1'b1 && we === 1'b0) || probe) begin
      if (notes.size() > 0) begin
        nt = notes.pop_front();
        `CHK(names[nt.kind], nt.exp, observe(nt.kind))
      end
    end
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    logic [31:0] r;
    n = 0;
    r = $random(seed);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= {r[23:0], d};
    @(posedge clock);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (wb_ack_o !== 1'b1) n_fail++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    notes.push_back('{0, {24'h0, e}});
    wb(1'b0, a, 8'h00, 4'hf);
  endtask

  task automatic expect_pin(input int k, input logic [31:0] e);
    notes.push_back('{k, e});
    probe <= 1'b1;
    @(posedge clock);
    probe <= 1'b0;
    @(posedge clock);
  endtask

  task automatic summarize;
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    summarize();
  end

  initial begin
    cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; dat = 32'h0000_0000; probe = 1'b0;
    reset_sequence = 1'b0; pb3 = 1'b1; ext_level = 8'hff;
    periph_i = '{timer0_output: 1'b0, timer1_output: 1'b0, timer0_pin_is_input: 1'b1, timer1_pin_is_input: 1'b1,
                 serial_driver_enable: 1'b1, serial_transmit: 1'b1, comparator_output: 1'b1,
                 debug_out: 1'b0, debug_oe: 1'b0};
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    expect_pin(1, 32'h0000_0000);
    rd(pmx_pkg::OFF_STATUS, 8'h00);
    reset_sequence <= 1'b1;
    repeat (12) @(posedge clock);
    reset_sequence <= 1'b0;
    ext_level <= 8'hfe;
    repeat (12) @(posedge clock);
    rd(pmx_pkg::OFF_STATUS, 8'h02);
    ext_level <= 8'hff;
    po = 8'($random(seed));
    wr(pmx_pkg::OFF_PA_OUT, po);
    wr(pmx_pkg::OFF_PA_DIR, 8'hff);
    wb(1'b1, pmx_pkg::OFF_PA_OUT, ~po, 4'he);
    rd(pmx_pkg::OFF_PA_OUT, po);
    rd(8'h3c, 8'h00);
    ext_level <= 8'hfb;
    wr(pmx_pkg::OFF_PA_AF, 8'h3f);
    for (int c = 0; c < 4; c++) begin
      // The timers are set so that only the correct polarity of a timer output reads 1.
      periph_i.timer0_output <= !c[0];
      periph_i.timer1_output <= c[1];
      wr(pmx_pkg::OFF_PA_FSL, {8{c[1]}});
      wr(pmx_pkg::OFF_PA_FSH, {8{c[0]}});
      eoe = 8'hc0;
      eout = po & 8'hc0;
      ean = 8'h00;
      for (int i = 0; i < 6; i++) begin
        cls = cls_tab[c][2 * i +: 2];
        eoe[i] = (cls < 2'd2);
        eout[i] = (cls == 2'd0) ? po[i] : (cls == 2'd1);
        ean[i] = (cls == 2'd3);
      end
      repeat (4) @(posedge clock);
      expect_pin(1, {24'h0, eoe});
      expect_pin(2, {24'h0, eout});
      expect_pin(3, {24'h0, ean});
      expect_pin(4, {25'h0, to_tab[c]});
    end
    periph_i.timer0_pin_is_input <= 1'b0;
    wr(pmx_pkg::OFF_PA_AF, 8'hff);
    repeat (4) @(posedge clock);
    expect_pin(8, 32'h0000_a7a5);
    expect_pin(9, 32'h0000_0038);
    wr(pmx_pkg::OFF_PA_AF, 8'h00);
    expect_pin(1, 32'h0000_00ff);
    expect_pin(2, {24'h0, po});
    wr(pmx_pkg::OFF_OSC, 8'h01);
    expect_pin(1, 32'h0000_00fc);
    rd(pmx_pkg::OFF_STATUS, 8'h06);
    wr(pmx_pkg::OFF_PB_AF, 8'h0f);
    wr(pmx_pkg::OFF_PB_FSL, 8'h05);
    wr(pmx_pkg::OFF_PC_AF, 8'h0f);
    wr(pmx_pkg::OFF_PC_FSL, 8'h05);
    wr(pmx_pkg::OFF_PD_AF, 8'h01);
    expect_pin(6, 32'h050a_050a);
    expect_pin(7, 32'h0000_0001);
    wr(pmx_pkg::OFF_OSC, 8'h02);
    expect_pin(5, 32'h0000_0001);
    expect_pin(9, 32'h0000_000c);
    // A second reset with the debug pin held low through the window must unlock debug.
    ext_level <= 8'hfe;
    rst <= 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    reset_sequence <= 1'b1;
    repeat (12) @(posedge clock);
    reset_sequence <= 1'b0;
    ext_level <= 8'hff;
    @(posedge clock);
    rd(pmx_pkg::OFF_STATUS, 8'h03);
    wr(pmx_pkg::OFF_PA_DIR, 8'hff);
    expect_pin(1, 32'h0000_00fe);
    summarize();
  end
endmodule
